// ### aod_decode.sv
// Contract
// - add reg/mem form, 3 or 10 clocks
// - immediate group, field selects op, 4/16
// - add-with-carry reg/mem form, 3 or 10
// - subtract reg/mem form, 3 or 10 clocks
// - accumulator immediates, word fetches two bytes
// - word operands add 4 per memory transfer
`default_nettype none
module aod_decode (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        in_valid,
   input  wire logic [7:0]  in_byte,
   output logic             in_ready,
   output logic             dec_valid,
   output logic             dec_unknown,
   output logic      [1:0]  dec_op,
   output logic      [1:0]  dec_form,
   output logic             dec_word,
   output logic             dec_dir,
   output logic      [1:0]  dec_mode,
   output logic      [2:0]  dec_reg,
   output logic      [2:0]  dec_rm,
   output logic      [15:0] dec_disp,
   output logic      [15:0] dec_imm,
   output logic      [5:0]  dec_clocks
);

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OPC   = 3'b000,
      ST_MODRM = 3'b001,
      ST_DLO   = 3'b010,
      ST_DHI   = 3'b011,
      ST_ILO   = 3'b100,
      ST_IHI   = 3'b101
   } aod_state_t;

   aod_state_t  state_r;
   aod_state_t  state_nxt;
   logic        take;
   logic [1:0]  op_r;
   logic [1:0]  form_r;
   logic        word_r;
   logic        dir_r;
   logic        sext_r;
   logic [1:0]  mode_r;
   logic [2:0]  reg_r;
   logic [2:0]  rm_r;
   logic [15:0] disp_r;
   logic [15:0] imm_r;
   logic        two_imm_r;
   logic        two_disp_r;
   logic        last;
   logic        bad_opc;
   logic        bad_grp;
   logic [5:0]  clocks;

   assign in_ready = 1'b1;
   assign take     = in_valid;

   // ----------------------------------------------------------------
   // opcode classification
   // ----------------------------------------------------------------
   logic        is_rm;
   logic        is_imm;
   logic        is_acc;
   logic [1:0]  opc_op;

   always_comb
   begin
      is_rm  = 1'b0;
      is_imm = 1'b0;
      is_acc = 1'b0;
      opc_op = aod_pkg::AOD_OP_ADD;
      if ((in_byte & aod_pkg::MASK_DW) == aod_pkg::PAT_ADD_RM)
      begin
         is_rm = 1'b1;
      end
      else if ((in_byte & aod_pkg::MASK_DW) == aod_pkg::PAT_ADC_RM)
      begin
         is_rm  = 1'b1;
         opc_op = aod_pkg::AOD_OP_ADC;
      end
      else if ((in_byte & aod_pkg::MASK_DW) == aod_pkg::PAT_SUB_RM)
      begin
         is_rm  = 1'b1;
         opc_op = aod_pkg::AOD_OP_SUB;
      end
      else if ((in_byte & aod_pkg::MASK_DW) == aod_pkg::PAT_IMM_GRP)
      begin
         is_imm = 1'b1;
      end
      else if ((in_byte & aod_pkg::MASK_W) == aod_pkg::PAT_ADD_ACC)
      begin
         is_acc = 1'b1;
      end
      else if ((in_byte & aod_pkg::MASK_W) == aod_pkg::PAT_ADC_ACC)
      begin
         is_acc = 1'b1;
         opc_op = aod_pkg::AOD_OP_ADC;
      end
      else if ((in_byte & aod_pkg::MASK_W) == aod_pkg::PAT_SUB_ACC)
      begin
         is_acc = 1'b1;
         opc_op = aod_pkg::AOD_OP_SUB;
      end
   end

   assign bad_opc = !(is_rm || is_imm || is_acc);

   // middle field of the immediate group
   logic [1:0] grp_op;
   logic [2:0] mid;
   logic [1:0] mb_mode;
   logic [2:0] mb_rm;

   assign mid     = in_byte[aod_pkg::REG_HI:aod_pkg::REG_LO];
   assign mb_mode = in_byte[aod_pkg::MOD_HI:aod_pkg::MOD_LO];
   assign mb_rm   = in_byte[aod_pkg::RM_HI:aod_pkg::RM_LO];

   always_comb
   begin
      grp_op  = aod_pkg::AOD_OP_ADD;
      bad_grp = 1'b0;
      unique case (mid)
         aod_pkg::GRP_ADD: grp_op = aod_pkg::AOD_OP_ADD;
         aod_pkg::GRP_ADC: grp_op = aod_pkg::AOD_OP_ADC;
         aod_pkg::GRP_SUB: grp_op = aod_pkg::AOD_OP_SUB;
         default:          bad_grp = 1'b1;
      endcase
   end

   // displacement bytes following the addressing byte
   logic mb_disp;
   logic mb_disp2;

   assign mb_disp2 = (mb_mode == aod_pkg::MOD_D16) ||
                     (mb_mode == aod_pkg::MOD_NODSP &&
                      mb_rm == aod_pkg::RM_DIRECT);
   assign mb_disp  = mb_disp2 || (mb_mode == aod_pkg::MOD_D8);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      last      = 1'b0;
      if (take)
      begin
         unique case (state_r)
            ST_OPC:
            begin
               if (bad_opc)
                  last = 1'b1;
               else if (is_acc)
                  state_nxt = ST_ILO;
               else
                  state_nxt = ST_MODRM;
            end
            ST_MODRM:
            begin
               if (form_r == aod_pkg::AOD_FORM_IMM && bad_grp)
               begin
                  state_nxt = ST_OPC;
                  last      = 1'b1;
               end
               else if (mb_disp)
                  state_nxt = ST_DLO;
               else if (form_r == aod_pkg::AOD_FORM_IMM)
                  state_nxt = ST_ILO;
               else
               begin
                  state_nxt = ST_OPC;
                  last      = 1'b1;
               end
            end
            ST_DLO:
            begin
               if (two_disp_r)
                  state_nxt = ST_DHI;
               else if (form_r == aod_pkg::AOD_FORM_IMM)
                  state_nxt = ST_ILO;
               else
               begin
                  state_nxt = ST_OPC;
                  last      = 1'b1;
               end
            end
            ST_DHI:
            begin
               if (form_r == aod_pkg::AOD_FORM_IMM)
                  state_nxt = ST_ILO;
               else
               begin
                  state_nxt = ST_OPC;
                  last      = 1'b1;
               end
            end
            ST_ILO:
            begin
               if (two_imm_r)
                  state_nxt = ST_IHI;
               else
               begin
                  state_nxt = ST_OPC;
                  last      = 1'b1;
               end
            end
            ST_IHI:
            begin
               state_nxt = ST_OPC;
               last      = 1'b1;
            end
            default:
            begin
               state_nxt = ST_OPC;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         state_r <= ST_OPC;
      else
         state_r <= state_nxt;
   end

   // ----------------------------------------------------------------
   // instruction fields
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         op_r       <= aod_pkg::AOD_OP_ADD;
         form_r     <= aod_pkg::AOD_FORM_RM;
         word_r     <= 1'b0;
         dir_r      <= 1'b0;
         sext_r     <= 1'b0;
         two_imm_r  <= 1'b0;
         mode_r     <= aod_pkg::MOD_REG;
         reg_r      <= 3'h0;
         rm_r       <= 3'h0;
         two_disp_r <= 1'b0;
      end
      else if (take && state_r == ST_OPC)
      begin
         op_r      <= opc_op;
         form_r    <= is_imm ? aod_pkg::AOD_FORM_IMM
                    : is_acc ? aod_pkg::AOD_FORM_ACC
                             : aod_pkg::AOD_FORM_RM;
         word_r    <= in_byte[aod_pkg::W_BIT];
         dir_r     <= is_rm && in_byte[aod_pkg::D_BIT];
         sext_r    <= is_imm && in_byte[aod_pkg::S_BIT];
         two_imm_r <= is_acc ? in_byte[aod_pkg::W_BIT]
                    : ({in_byte[aod_pkg::S_BIT], in_byte[aod_pkg::W_BIT]}
                       == aod_pkg::SW_WORDIMM);
         mode_r    <= aod_pkg::MOD_REG;
      end
      else if (take && state_r == ST_MODRM)
      begin
         mode_r     <= mb_mode;
         reg_r      <= mid;
         rm_r       <= mb_rm;
         two_disp_r <= mb_disp2;
         if (form_r == aod_pkg::AOD_FORM_IMM)
            op_r <= grp_op;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         disp_r <= 16'h0000;
      else if (take && state_r == ST_OPC)
         disp_r <= 16'h0000;
      else if (take && state_r == ST_DLO)
         disp_r <= {{8{in_byte[aod_pkg::SIGN_BIT]}}, in_byte};
      else if (take && state_r == ST_DHI)
         disp_r <= {in_byte, disp_r[7:0]};
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         imm_r <= 16'h0000;
      else if (take && state_r == ST_ILO)
         imm_r <= (sext_r && word_r)
                ? {{8{in_byte[aod_pkg::SIGN_BIT]}}, in_byte}
                : {8'h00, in_byte};
      else if (take && state_r == ST_IHI)
         imm_r <= {in_byte, imm_r[7:0]};
   end

   // ----------------------------------------------------------------
   // clock count
   // ----------------------------------------------------------------
   aod_timing u_timing (
      .form   (form_r),
      .word   (word_r),
      .dir    (dir_r),
      .mode   (mode_r),
      .clocks (clocks)
   );

   // ----------------------------------------------------------------
   // result outputs
   // ----------------------------------------------------------------
   logic fin_r;
   logic unk_r;

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         fin_r <= 1'b0;
         unk_r <= 1'b0;
      end
      else
      begin
         fin_r <= last && !(state_r == ST_OPC) &&
                  !(state_r == ST_MODRM && form_r == aod_pkg::AOD_FORM_IMM
                    && bad_grp);
         unk_r <= last && (state_r == ST_OPC ||
                  (state_r == ST_MODRM &&
                   form_r == aod_pkg::AOD_FORM_IMM && bad_grp));
      end
   end

   assign dec_valid   = fin_r;
   assign dec_unknown = unk_r;
   assign dec_op      = op_r;
   assign dec_form    = form_r;
   assign dec_word    = word_r;
   assign dec_dir     = dir_r;
   assign dec_mode    = mode_r;
   assign dec_reg     = reg_r;
   assign dec_rm      = rm_r;
   assign dec_disp    = disp_r;
   assign dec_imm     = imm_r;
   assign dec_clocks  = clocks;

endmodule : aod_decode
`default_nettype wire

// ### aod_pkg.sv
`default_nettype none
package aod_pkg;

   // ----------------------------------------------------------------
   // operation and form codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AOD_OP_ADD = 2'b00,
      AOD_OP_ADC = 2'b01,
      AOD_OP_SUB = 2'b10
   } aod_op_t;

   typedef enum logic [1:0] {
      AOD_FORM_RM  = 2'b00,
      AOD_FORM_IMM = 2'b01,
      AOD_FORM_ACC = 2'b10
   } aod_form_t;

   // ----------------------------------------------------------------
   // opcode patterns
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_DW     = 8'hFC;
   localparam logic [7:0] MASK_W      = 8'hFE;
   localparam logic [7:0] PAT_ADD_RM  = 8'h00;
   localparam logic [7:0] PAT_ADC_RM  = 8'h10;
   localparam logic [7:0] PAT_SUB_RM  = 8'h28;
   localparam logic [7:0] PAT_IMM_GRP = 8'h80;
   localparam logic [7:0] PAT_ADD_ACC = 8'h04;
   localparam logic [7:0] PAT_ADC_ACC = 8'h14;
   localparam logic [7:0] PAT_SUB_ACC = 8'h2C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int W_BIT   = 0;
   localparam int D_BIT   = 1;
   localparam int S_BIT   = 1;
   localparam int MOD_HI  = 7;
   localparam int MOD_LO  = 6;
   localparam int REG_HI  = 5;
   localparam int REG_LO  = 3;
   localparam int RM_HI   = 2;
   localparam int RM_LO   = 0;
   localparam int SIGN_BIT = 7;

   localparam logic [2:0] GRP_ADD   = 3'h0;
   localparam logic [2:0] GRP_ADC   = 3'h2;
   localparam logic [2:0] GRP_SUB   = 3'h5;
   localparam logic [1:0] MOD_REG   = 2'h3;
   localparam logic [1:0] MOD_D8    = 2'h1;
   localparam logic [1:0] MOD_D16   = 2'h2;
   localparam logic [1:0] MOD_NODSP = 2'h0;
   localparam logic [2:0] RM_DIRECT = 3'h6;
   localparam logic [1:0] SW_WORDIMM = 2'h1;

   // ----------------------------------------------------------------
   // clock counts
   // ----------------------------------------------------------------
   localparam logic [5:0] CLK_RM_REG  = 6'h03;
   localparam logic [5:0] CLK_RM_MEM  = 6'h0A;
   localparam logic [5:0] CLK_IMM_REG = 6'h04;
   localparam logic [5:0] CLK_IMM_MEM = 6'h10;
   localparam logic [5:0] CLK_ACC_B   = 6'h03;
   localparam logic [5:0] CLK_ACC_W   = 6'h04;
   localparam logic [5:0] CLK_WORD_XF = 6'h04;

endpackage : aod_pkg
`default_nettype wire

// ### aod_timing.sv
`default_nettype none
module aod_timing (
   input  wire logic [1:0] form,
   input  wire logic       word,
   input  wire logic       dir,
   input  wire logic [1:0] mode,
   output logic      [5:0] clocks
);

   // ----------------------------------------------------------------
   // clock count per form
   // ----------------------------------------------------------------
   logic       mem_op;
   logic       mem_wr;
   logic [5:0] base;
   logic [5:0] extra;

   always_comb
   begin
      mem_op = (mode != aod_pkg::MOD_REG);
      mem_wr = 1'b0;
      base   = aod_pkg::CLK_ACC_B;
      unique case (form)
         aod_pkg::AOD_FORM_RM:
         begin
            base   = mem_op ? aod_pkg::CLK_RM_MEM
                            : aod_pkg::CLK_RM_REG;
            mem_wr = mem_op && !dir;
         end
         aod_pkg::AOD_FORM_IMM:
         begin
            base   = mem_op ? aod_pkg::CLK_IMM_MEM
                            : aod_pkg::CLK_IMM_REG;
            mem_wr = mem_op;
         end
         default:
         begin
            mem_op = 1'b0;
            base   = word ? aod_pkg::CLK_ACC_W
                          : aod_pkg::CLK_ACC_B;
         end
      endcase
      // word operands: one surcharge per memory transfer
      extra = 6'h00;
      if (word && mem_op)
      begin
         extra = mem_wr ? 6'(aod_pkg::CLK_WORD_XF + aod_pkg::CLK_WORD_XF)
                        : aod_pkg::CLK_WORD_XF;
      end
      clocks = 6'(base + extra);
   end

endmodule : aod_timing
`default_nettype wire

// ### aod_decode_checker.sv
`default_nettype none
module aod_decode_checker (
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        in_valid,
   input wire logic [7:0]  in_byte,
   input wire logic        in_ready,
   input wire logic        dec_valid,
   input wire logic        dec_unknown,
   input wire logic [1:0]  dec_op,
   input wire logic [1:0]  dec_form,
   input wire logic        dec_word,
   input wire logic        dec_dir,
   input wire logic [1:0]  dec_mode,
   input wire logic [2:0]  dec_reg,
   input wire logic [2:0]  dec_rm,
   input wire logic [15:0] dec_disp,
   input wire logic [15:0] dec_imm,
   input wire logic [5:0]  dec_clocks
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // completion sequences
   // ----------------------------------------------------------------
   sequence s_rm_done;
      dec_valid && dec_form == 2'h0;
   endsequence
   sequence s_imm_done;
      dec_valid && dec_form == 2'h1;
   endsequence
   sequence s_acc_done;
      dec_valid && dec_form == 2'h2;
   endsequence

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   pulse_cause_a: assert property (
      dec_valid || dec_unknown |-> $past(in_valid))
      else $error("result pulse without a byte taken");
   pulse_excl_a: assert property (
      !(dec_valid && dec_unknown))
      else $error("valid and unknown together");
   no_back_a: assert property (
      dec_valid |=> !dec_valid)
      else $error("two results in adjacent cycles");
   rm_reg_clk_a: assert property (
      s_rm_done ##0 dec_mode == 2'h3 |-> dec_clocks == 6'h03)
      else $error("register form clock count wrong");
   rm_mem_clk_a: assert property (
      s_rm_done ##0 dec_mode != 2'h3 |-> dec_clocks ==
         (!dec_word ? 6'h0A : dec_dir ? 6'h0E : 6'h12))
      else $error("memory form clock count wrong");
   imm_clk_a: assert property (
      s_imm_done |-> dec_clocks == (dec_mode == 2'h3 ? 6'h04 :
         dec_word ? 6'h18 : 6'h10))
      else $error("immediate group clock count wrong");
   imm_op_a: assert property (
      s_imm_done |-> !dec_dir && (dec_reg == 3'h0 && dec_op == 2'h0 ||
         dec_reg == 3'h2 && dec_op == 2'h1 ||
         dec_reg == 3'h5 && dec_op == 2'h2))
      else $error("immediate group operation wrong");
   acc_clk_a: assert property (
      s_acc_done |-> dec_mode == 2'h3 && !dec_dir &&
         dec_clocks == (dec_word ? 6'h04 : 6'h03))
      else $error("accumulator form result wrong");
   acc_byte_a: assert property (
      s_acc_done ##0 !dec_word |-> dec_imm[15:8] == 8'h00)
      else $error("byte immediate not zero extended");
   disp_sext_a: assert property (
      dec_valid && dec_mode == 2'h1 |-> dec_disp[15:8] == {8{dec_disp[7]}})
      else $error("short displacement not sign extended");
endmodule : aod_decode_checker

bind aod_decode aod_decode_checker i_aod_decode_checker (
   .mclk(mclk), .reset(reset), .in_valid(in_valid), .in_byte(in_byte),
   .in_ready(in_ready), .dec_valid(dec_valid), .dec_unknown(dec_unknown),
   .dec_op(dec_op), .dec_form(dec_form), .dec_word(dec_word),
   .dec_dir(dec_dir), .dec_mode(dec_mode), .dec_reg(dec_reg),
   .dec_rm(dec_rm), .dec_disp(dec_disp), .dec_imm(dec_imm),
   .dec_clocks(dec_clocks));
`default_nettype wire

// ### arith_opcode_decode_timing_tb.sv
`default_nettype none
module arith_opcode_decode_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {int due; logic [47:0] val, msk; logic [5:0] clk;} aod_exp_t;

   logic        mclk, reset, in_valid, in_ready, dec_valid, dec_unknown;
   logic        dec_word, dec_dir;
   logic [7:0]  in_byte;
   logic [1:0]  dec_op, dec_form, dec_mode;
   logic [2:0]  dec_reg, dec_rm;
   logic [15:0] dec_disp, dec_imm;
   logic [5:0]  dec_clocks;
   logic [31:0] r, r2;
   int          failures, checks_done, cyc;
   aod_exp_t    exp_q[$];
   aod_exp_t    m;
   wire  [47:0] seen = {dec_valid, dec_unknown, dec_op, dec_form, dec_word,
      dec_dir, dec_mode, dec_reg, dec_rm, dec_disp, dec_imm};

   aod_decode i_aod_decode (.mclk(mclk), .reset(reset), .in_valid(in_valid),
      .in_byte(in_byte), .in_ready(in_ready), .dec_valid(dec_valid),
      .dec_unknown(dec_unknown), .dec_op(dec_op), .dec_form(dec_form),
      .dec_word(dec_word), .dec_dir(dec_dir), .dec_mode(dec_mode),
      .dec_reg(dec_reg), .dec_rm(dec_rm), .dec_disp(dec_disp),
      .dec_imm(dec_imm), .dec_clocks(dec_clocks));

   // ----------------------------------------------------------------
   // clock, checking and closing
   // ----------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task check(input logic [47:0] got, input logic [47:0] want);
      checks_done++;
      if (got !== want)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, want);
      end
   endtask : check

   task give_verdict;
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   always @(posedge mclk)
   begin
      if (!reset && exp_q.size() != 0 && exp_q[0].due == cyc)
      begin
         m = exp_q.pop_front();
         check({47'h0, in_ready}, 48'h1);
         check(seen & m.msk, m.val & m.msk);
         if (m.val[47])
            check({42'h0, dec_clocks}, {42'h0, m.clk});
      end
      else if (!reset)
         check({46'h0, dec_valid, dec_unknown}, 48'h0);
      cyc++;
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   task put(input logic [7:0] b);
      @(negedge mclk);
      if ($urandom_range(3) == 0)
      begin
         in_valid = 1'b0;
         @(negedge mclk);
      end
      in_valid = 1'b1;
      in_byte  = b;
   endtask : put

   task expect_at(input logic [47:0] v, msk, input logic [5:0] c);
      aod_exp_t e;
      e.due = cyc + 1;
      e.val = v;
      e.msk = msk;
      e.clk = c;
      exp_q.push_back(e);
   endtask : expect_at

   function automatic logic [5:0] exp_clocks(input logic [1:0] fm, md,
      input logic w, d);
      logic [5:0] mem_extra;
      mem_extra = !w ? 6'h00 : (fm == 2'h0 && d) ? 6'h04 : 6'h08;
      if (fm == 2'h2)
         return w ? 6'h04 : 6'h03;
      else if (md == 2'h3)
         return fm == 2'h0 ? 6'h03 : 6'h04;
      else
         return (fm == 2'h0 ? 6'h0A : 6'h10) + mem_extra;
   endfunction : exp_clocks

   task instr(input logic [1:0] op, fm, input logic d, w, s,
      input logic [1:0] md, input logic [2:0] rg, rm,
      input logic [15:0] dsp, im);
      logic [7:0]  opc;
      logic [2:0]  grp;
      logic [15:0] xd, xi;
      logic [5:0]  c;
      logic [47:0] msk;
      int          nd, ni;
      grp = op == 2'h0 ? 3'h0 : op == 2'h1 ? 3'h2 : 3'h5;
      msk = 48'hFFFF_FFFF_FFFF;
      nd = md == 2'h1 ? 1 : (md == 2'h2 || md == 2'h0 && rm == 3'h6) ? 2 : 0;
      ni = w ? 2 : 1;
      if (fm == 2'h0)
      begin
         opc = (op == 2'h0 ? aod_pkg::PAT_ADD_RM : op == 2'h1 ?
            aod_pkg::PAT_ADC_RM : aod_pkg::PAT_SUB_RM) | {6'h0, d, w};
         ni = 0;
         msk[15:0] = 16'h0;
      end
      else if (fm == 2'h1)
      begin
         opc = aod_pkg::PAT_IMM_GRP | {6'h0, s, w};
         ni = {s, w} == 2'b01 ? 2 : 1;
         rg = grp;
         d = 1'b0;
      end
      else
      begin
         opc = (op == 2'h0 ? aod_pkg::PAT_ADD_ACC : op == 2'h1 ?
            aod_pkg::PAT_ADC_ACC : aod_pkg::PAT_SUB_ACC) | {7'h0, w};
         md = 2'h3;
         nd = 0;
         d = 1'b0;
         msk[37:16] = 22'h0;
      end
      c = exp_clocks(fm, md, w, d);
      xd = nd == 1 ? {{8{dsp[7]}}, dsp[7:0]} : nd == 2 ? dsp : 16'h0;
      xi = ni == 2 ? im : {(s & w & fm == 2'h1) ? {8{im[7]}} : 8'h0, im[7:0]};
      put(opc);
      if (fm != 2'h2)
         put({md, rg, rm});
      for (int i = 0; i < nd; i++)
         put(dsp[8*i +: 8]);
      for (int i = 0; i < ni; i++)
         put(im[8*i +: 8]);
      expect_at({2'b10, op, fm, w, d, md, rg, rm, xd, xi}, msk, c);
   endtask : instr

   task bad(input logic [7:0] b0, b1, input logic two);
      put(b0);
      if (two)
         put(b1);
      expect_at(48'h4000_0000_0000, 48'hC000_0000_0000, 6'h0);
   endtask : bad

   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      give_verdict();
   end

   initial
   begin
      reset = 1'b1;
      in_valid = 1'b0;
      in_byte = 8'h00;
      cyc = 0;
      void'($urandom(71));
      repeat (6) @(negedge mclk);
      reset = 1'b0;
      instr(2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 2'h3, 3'h1, 3'h0, 16'h0, 16'h0);
      instr(2'h2, 2'h1, 1'b0, 1'b1, 1'b0, 2'h0, 3'h0, 3'h6, 16'h1234,
         16'h5678);
      instr(2'h1, 2'h2, 1'b0, 1'b0, 1'b0, 2'h3, 3'h0, 3'h0, 16'h0, 16'h007F);
      instr(2'h0, 2'h1, 1'b0, 1'b1, 1'b1, 2'h3, 3'h0, 3'h1, 16'h0, 16'h0080);
      bad(8'h06, 8'h00, 1'b0);
      bad(8'h18, 8'h00, 1'b0);
      bad(8'h81, 8'hC8, 1'b1);
      bad(8'h83, 8'hD8, 1'b1);
      for (int i = 0; i < 72; i++)
         instr(2'(i % 3), 2'((i / 3) % 3), i[0], i[1], i[2], 2'((i / 9) % 4),
            3'(i), 3'h6, 16'h8081, 16'h80FE);
      put(8'h81);
      @(negedge mclk);
      in_valid = 1'b0;
      reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      repeat (300)
      begin
         r = $urandom;
         r2 = $urandom;
         instr(2'($urandom_range(2)), 2'($urandom_range(2)), r[0], r[1], r[2],
            r[4:3], r[7:5], r[10:8], r2[15:0], r2[31:16]);
      end
      @(negedge mclk);
      in_valid = 1'b0;
      repeat (4) @(negedge mclk);
      check(48'(exp_q.size()), 48'h0);
      give_verdict();
   end
endmodule : arith_opcode_decode_timing_tb
`default_nettype wire
